// ==== rtl/cas_pkg.sv ====
// constants, action codes and entry layout for the condition/action scripter
// assumes a single 200 MHz system clock shared by every user of this package
package cas_pkg;
    localparam int N_ENTRY = 16;
    localparam int N_CNT   = 8;
    localparam int N_TMR   = 8;
    localparam int N_GPIO  = 8;
    localparam int CNT_W   = 32;
    localparam int EV_W    = 8;
    localparam int MASK_W  = EV_W + N_TMR;
    localparam int SEL_W   = 3;
    localparam int IDX_W   = 5;
    localparam int ENT_W   = 4;
    localparam int TOK_W   = 4;
    localparam int LEN_W   = 11;
    localparam int TMR_W   = 16;
    localparam int TICK_W  = 32;

    localparam logic [IDX_W-1:0] IDX_LIMIT = 5'h10;
    localparam logic [TOK_W-1:0] TOK_MAX   = 4'h8;
    localparam logic [LEN_W-1:0] LEN_MAX   = 11'h5C0;
    localparam logic [CNT_W-1:0] CNT_STEP  = 32'h1;
    localparam logic [TMR_W-1:0] TMR_ONE   = 16'h1;
    localparam logic [TICK_W-1:0] TICK_ONE = 32'h1;

    localparam longint CLK_HZ   = 200000000;
    localparam longint TICK_S   = 1;
    localparam int     TICK_CYC = int'(CLK_HZ * TICK_S);

    typedef enum logic [3:0] {
        ACT_NONE     = 4'h0,
        ACT_RAW_TX   = 4'h1,
        ACT_UDP_TX   = 4'h2,
        ACT_TCP_TX   = 4'h3,
        ACT_CNT_INC  = 4'h4,
        ACT_CNT_SET  = 4'h5,
        ACT_TMR_CTL  = 4'h6,
        ACT_GPIO_SET = 4'h7,
        ACT_HIBERN   = 4'h8,
        ACT_SET_ROLE = 4'h9,
        ACT_DEL_PROF = 4'hA,
        ACT_CONN_POL = 4'hB,
        ACT_HW_IND   = 4'hC
    } cas_act_t;

    typedef struct packed {
        logic                valid;
        logic                init;
        logic [MASK_W-1:0]   mask;
        cas_act_t            act;
        logic [SEL_W-1:0]    sel;
        logic [CNT_W-1:0]    value;
        logic [TOK_W-1:0]    tokens;
        logic [LEN_W-1:0]    len;
    } cas_entry_t;

    function automatic logic cas_init_only(input cas_act_t a);
        return (a == ACT_SET_ROLE) || (a == ACT_DEL_PROF) ||
               (a == ACT_CONN_POL) || (a == ACT_HW_IND);
    endfunction
endpackage

// ==== rtl/cas_tmr.sv ====
// bank of user timers counting whole seconds from a shared prescaler
// assumes loads arrive as one-cycle strobes from the scripter core
module cas_tmr #(
    parameter int TICK_CYC = cas_pkg::TICK_CYC
) (
    input  wire logic clk,   // system clock
    input  wire logic rst,   // async reset, active high
    cas_tmr_if.tmr    tif    // load strobes in, expiry and run status out
);
    localparam logic [cas_pkg::TICK_W-1:0] TICK_LAST = cas_pkg::TICK_W'(TICK_CYC - 1);

    typedef struct packed {
        logic [cas_pkg::TICK_W-1:0]                   tick;
        logic [cas_pkg::N_TMR-1:0][cas_pkg::TMR_W-1:0] rem;
        logic [cas_pkg::N_TMR-1:0]                    run;
        logic [cas_pkg::N_TMR-1:0]                    exp;
    } cas_tmr_st_t;

    cas_tmr_st_t s_q;
    cas_tmr_st_t s_d;
    logic        tick_now;

    // one shared prescaler: a started timer may run short by up to one second
    assign tick_now = (s_q.tick == TICK_LAST);

    always_comb begin
        s_d = s_q;
        s_d.exp = '0;
        s_d.tick = tick_now ? '0 : s_q.tick + cas_pkg::TICK_ONE;
        for (int i = 0; i < cas_pkg::N_TMR; i++) begin
            if (tif.ld[i]) begin
                s_d.rem[i] = tif.ld_val;
                s_d.run[i] = (tif.ld_val != '0);
            end else if (tick_now && s_q.run[i]) begin
                if (s_q.rem[i] == cas_pkg::TMR_ONE) begin
                    s_d.run[i] = 1'b0;
                    s_d.exp[i] = 1'b1;
                    s_d.rem[i] = '0;
                end else begin
                    s_d.rem[i] = s_q.rem[i] - cas_pkg::TMR_ONE;
                end
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tif.expired = s_q.exp;
    assign tif.running = s_q.run;
endmodule

// ==== rtl/cas_tmr_if.sv ====
// timer load strobes and timer status between scripter core and timer bank
// assumes both ends sit on the same clock
interface cas_tmr_if;
    logic [cas_pkg::N_TMR-1:0] ld;
    logic [cas_pkg::TMR_W-1:0] ld_val;
    logic [cas_pkg::N_TMR-1:0] expired;
    logic [cas_pkg::N_TMR-1:0] running;
    modport ctl (output ld, output ld_val, input expired, input running);
    modport tmr (input ld, input ld_val, output expired, output running);
endinterface

// ==== rtl/cas_top.sv ====
// condition/action scripter: entry table, trigger detection, action dispatch
// assumes the networking core accepts requests on act_valid/act_ready at its own pace
module cas_top #(
    parameter int TICK_CYC = cas_pkg::TICK_CYC
) (
    input  wire logic                       clk,         // system clock, 200 MHz
    input  wire logic                       rst,         // async reset, active high
    input  wire logic                       pre_init,    // initialization phase level
    input  wire logic [cas_pkg::EV_W-1:0]   ev,          // external sub-condition levels
    input  wire logic                       cfg_we,      // entry write strobe
    input  wire logic [cas_pkg::IDX_W-1:0]  cfg_idx,     // entry index
    input  wire logic                       cfg_valid,   // entry enabled
    input  wire logic                       cfg_init,    // entry uses pre-init trigger
    input  wire logic [cas_pkg::MASK_W-1:0] cfg_mask,    // sub-conditions to AND
    input  wire cas_pkg::cas_act_t          cfg_act,     // action code
    input  wire logic [cas_pkg::SEL_W-1:0]  cfg_sel,     // counter/timer/pin/role select
    input  wire logic [cas_pkg::CNT_W-1:0]  cfg_value,   // action value
    input  wire logic [cas_pkg::TOK_W-1:0]  cfg_tokens,  // packet token count
    input  wire logic [cas_pkg::LEN_W-1:0]  cfg_len,     // packet payload length
    output logic                            cfg_ack,     // write accepted, pulse
    output logic                            cfg_err,     // write refused, pulse
    output logic                            act_valid,   // request to networking core
    input  wire logic                       act_ready,   // core takes request
    output cas_pkg::cas_act_t               act_kind,    // requested action
    output logic [cas_pkg::ENT_W-1:0]       act_entry,   // entry that fired
    output logic [cas_pkg::SEL_W-1:0]       act_sel,     // select field
    output logic [cas_pkg::CNT_W-1:0]       act_value,   // value field
    output logic [cas_pkg::TOK_W-1:0]       act_tokens,  // token count
    output logic [cas_pkg::LEN_W-1:0]       act_len,     // payload length
    input  wire logic                       core_ind,    // radio-core indication signal
    output logic [cas_pkg::N_GPIO-1:0]      gpio_out,    // script-driven outputs
    output logic                            hib,         // hibernate requested, level
    input  wire logic                       wake,        // leaves hibernate
    input  wire logic [cas_pkg::SEL_W-1:0]  cnt_rd_sel,  // counter read select
    output logic [cas_pkg::CNT_W-1:0]       cnt_rd_data, // counter read data
    output logic [cas_pkg::N_TMR-1:0]       tmr_running  // timer run status
);
    typedef struct packed {
        cas_pkg::cas_entry_t [cas_pkg::N_ENTRY-1:0]     ent;
        logic [cas_pkg::N_ENTRY-1:0]                    pend;
        logic [cas_pkg::N_ENTRY-1:0]                    cond_prev;
        logic                                           pre_prev;
        logic [cas_pkg::N_CNT-1:0][cas_pkg::CNT_W-1:0]  cnt;
        logic                                           busy;
        cas_pkg::cas_act_t                              kind;
        logic [cas_pkg::ENT_W-1:0]                      entry;
        logic [cas_pkg::SEL_W-1:0]                      sel;
        logic [cas_pkg::CNT_W-1:0]                      value;
        logic [cas_pkg::TOK_W-1:0]                      tokens;
        logic [cas_pkg::LEN_W-1:0]                      len;
        logic [cas_pkg::N_TMR-1:0]                      tmr_ld;
        logic [cas_pkg::TMR_W-1:0]                      tmr_val;
        logic [cas_pkg::N_GPIO-1:0]                     gpio;
        logic [cas_pkg::N_GPIO-1:0]                     gpio_drv;
        logic                                           ind_en;
        logic [cas_pkg::SEL_W-1:0]                      ind_sel;
        logic                                           hib;
        logic                                           ack;
        logic                                           err;
        logic [cas_pkg::CNT_W-1:0]                      rd;
    } cas_state_t;

    cas_state_t                   s_q;
    cas_state_t                   s_d;
    cas_tmr_if                    tif ();
    logic [cas_pkg::MASK_W-1:0]   cond_vec;
    logic                         pre_rise;
    logic [cas_pkg::N_ENTRY-1:0]  trig;
    logic [cas_pkg::N_ENTRY-1:0]  fire;
    logic [cas_pkg::N_ENTRY-1:0]  clr;
    logic                         cfg_bad;
    logic                         pick_ok;
    logic [cas_pkg::ENT_W-1:0]    pick;
    cas_pkg::cas_entry_t          pe;

    assign cond_vec = {tif.expired, ev};
    assign pre_rise = pre_init & ~s_q.pre_prev;

    // runtime entries fire on the false-to-true edge, so a held level runs once
    always_comb begin
        trig = '0;
        fire = '0;
        for (int e = 0; e < cas_pkg::N_ENTRY; e++) begin
            if (s_q.ent[e].valid) begin
                if (s_q.ent[e].init) begin
                    trig[e] = pre_rise && ((cond_vec & s_q.ent[e].mask) == s_q.ent[e].mask);
                    fire[e] = trig[e];
                end else begin
                    trig[e] = (s_q.ent[e].mask != '0) &&
                              ((cond_vec & s_q.ent[e].mask) == s_q.ent[e].mask);
                    fire[e] = trig[e] & ~s_q.cond_prev[e];
                end
            end
        end
    end

    // lowest pending index wins
    always_comb begin
        pick_ok = 1'b0;
        pick = '0;
        for (int e = cas_pkg::N_ENTRY - 1; e >= 0; e--) begin
            if (s_q.pend[e]) begin
                pick_ok = 1'b1;
                pick = cas_pkg::ENT_W'(e);
            end
        end
    end

    assign pe = s_q.ent[pick];

    assign cfg_bad = (cfg_idx >= cas_pkg::IDX_LIMIT) ||
                     (cfg_tokens > cas_pkg::TOK_MAX) ||
                     (cfg_len > cas_pkg::LEN_MAX) ||
                     (!cfg_init && cas_pkg::cas_init_only(cfg_act));

    always_comb begin
        s_d = s_q;
        clr = '0;
        s_d.ack = 1'b0;
        s_d.err = 1'b0;
        s_d.tmr_ld = '0;
        s_d.pre_prev = pre_init;
        s_d.cond_prev = trig;
        if (cfg_we) begin
            if (cfg_bad) begin
                s_d.err = 1'b1;
            end else begin
                s_d.ack = 1'b1;
                s_d.ent[cfg_idx[cas_pkg::ENT_W-1:0]] = '{valid: cfg_valid, init: cfg_init,
                    mask: cfg_mask, act: cfg_act, sel: cfg_sel, value: cfg_value,
                    tokens: cfg_tokens, len: cfg_len};
                clr[cfg_idx[cas_pkg::ENT_W-1:0]] = 1'b1;
            end
        end
        if (s_q.busy && act_ready) begin
            s_d.busy = 1'b0;
            unique case (s_q.kind)
                cas_pkg::ACT_GPIO_SET: s_d.gpio[s_q.sel] = s_q.value[0];
                cas_pkg::ACT_HIBERN:   s_d.hib = 1'b1;
                cas_pkg::ACT_HW_IND: begin
                    s_d.ind_en = 1'b1;
                    s_d.ind_sel = s_q.sel;
                end
                default: ;
            endcase
        end else if (!s_q.busy && pick_ok) begin
            clr[pick] = 1'b1;
            unique case (pe.act)
                cas_pkg::ACT_CNT_INC: s_d.cnt[pe.sel] = s_q.cnt[pe.sel] + cas_pkg::CNT_STEP;
                cas_pkg::ACT_CNT_SET: s_d.cnt[pe.sel] = pe.value;
                cas_pkg::ACT_TMR_CTL: begin
                    s_d.tmr_ld[pe.sel] = 1'b1;
                    s_d.tmr_val = pe.value[cas_pkg::TMR_W-1:0];
                end
                cas_pkg::ACT_NONE: ;
                default: begin
                    s_d.busy = 1'b1;
                    s_d.kind = pe.act;
                    s_d.entry = pick;
                    s_d.sel = pe.sel;
                    s_d.value = pe.value;
                    s_d.tokens = pe.tokens;
                    s_d.len = pe.len;
                end
            endcase
        end
        if (wake) begin
            s_d.hib = 1'b0;
        end
        // a trigger in the same cycle as its clear stays pending
        s_d.pend = (s_q.pend & ~clr) | fire;
        for (int g = 0; g < cas_pkg::N_GPIO; g++) begin
            s_d.gpio_drv[g] = (s_q.ind_en && (s_q.ind_sel == cas_pkg::SEL_W'(g))) ?
                              core_ind : s_q.gpio[g];
        end
        s_d.rd = s_q.cnt[cnt_rd_sel];
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tif.ld      = s_q.tmr_ld;
    assign tif.ld_val  = s_q.tmr_val;
    assign cfg_ack     = s_q.ack;
    assign cfg_err     = s_q.err;
    assign act_valid   = s_q.busy;
    assign act_kind    = s_q.kind;
    assign act_entry   = s_q.entry;
    assign act_sel     = s_q.sel;
    assign act_value   = s_q.value;
    assign act_tokens  = s_q.tokens;
    assign act_len     = s_q.len;
    assign gpio_out    = s_q.gpio_drv;
    assign hib         = s_q.hib;
    assign cnt_rd_data = s_q.rd;
    assign tmr_running = tif.running;

    cas_tmr #(
        .TICK_CYC (TICK_CYC)
    ) i_cas_tmr (
        .clk (clk),
        .rst (rst),
        .tif (tif)
    );
endmodule

// ==== tb/cas_top_bench.sv ====
// directed bench for the scripter: entry writes, triggers, core handshake
// assumes a short prescaler so one script second is TICK cycles
module cas_top_bench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int TICK = 20;
    logic clk = 0, rst = 1, pre_init = 0, cfg_we = 0, cfg_valid = 0, cfg_init = 0;
    logic act_ready = 0, core_ind = 0, wake = 0, cfg_ack, cfg_err, act_valid, hib;
    logic [7:0] ev = 0, gpio_out, tmr_running;
    logic [4:0] cfg_idx = 0;
    logic [15:0] cfg_mask = 0;
    logic [2:0] cfg_sel = 0, cnt_rd_sel = 0, act_sel;
    logic [31:0] cfg_value = 0, act_value, cnt_rd_data;
    logic [3:0] cfg_tokens = 0, act_tokens, act_entry;
    logic [10:0] cfg_len = 0, act_len;
    cas_pkg::cas_act_t cfg_act = cas_pkg::ACT_NONE, act_kind;
    cas_pkg::cas_act_t snd [3] = '{cas_pkg::ACT_RAW_TX, cas_pkg::ACT_UDP_TX, cas_pkg::ACT_TCP_TX};
    int num_errors = 0, n_compared = 0;

    cas_top #(.TICK_CYC(TICK)) i_cas_top (.clk, .rst, .pre_init, .ev, .cfg_we, .cfg_idx,
        .cfg_valid, .cfg_init, .cfg_mask, .cfg_act, .cfg_sel, .cfg_value, .cfg_tokens,
        .cfg_len, .cfg_ack, .cfg_err, .act_valid, .act_ready, .act_kind, .act_entry,
        .act_sel, .act_value, .act_tokens, .act_len, .core_ind, .gpio_out, .hib, .wake,
        .cnt_rd_sel, .cnt_rd_data, .tmr_running);

    always #2.5 clk = ~clk;

    task automatic results;
        if (num_errors == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [4:0] i, input logic n, input logic [15:0] m,
                      input cas_pkg::cas_act_t a, input logic [2:0] s, input logic [31:0] v,
                      input logic [3:0] t, input logic [10:0] l, input logic bad);
        @(negedge clk);
        {cfg_we, cfg_valid, cfg_idx, cfg_init, cfg_mask} = {2'b11, i, n, m};
        {cfg_sel, cfg_value, cfg_tokens, cfg_len} = {s, v, t, l};
        cfg_act = a;
        @(negedge clk);
        cfg_we = 0;
        check({cfg_ack, cfg_err}, {!bad, bad});
    endtask

    task automatic rd(input logic [2:0] s, input logic [31:0] exp);
        cnt_rd_sel = s;
        repeat (2) @(negedge clk);
        check(cnt_rd_data, exp);
    endtask

    // the core answers two cycles late at best; the request must simply stand
    task automatic take(input cas_pkg::cas_act_t k, input logic [3:0] e, input logic [2:0] s,
                        input logic [31:0] v, input logic [3:0] t, input logic [10:0] l);
        int i;
        for (i = 0; i < 40 && act_valid !== 1'b1; i++) @(negedge clk);
        repeat (2) @(negedge clk);
        check({act_valid, act_kind, act_entry, act_sel, act_tokens, act_len},
              {1'b1, k, e, s, t, l});
        check(act_value, v);
        act_ready = 1;
        @(negedge clk);
        act_ready = 0;
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        results();
    end

    initial begin
        repeat (12) @(negedge clk);
        rst = 0;
        wr(5'h10, 0, 16'h0001, cas_pkg::ACT_CNT_INC, 0, 0, 0, 0, 1);
        wr(5'h08, 0, 16'h0040, cas_pkg::ACT_SET_ROLE, 0, 0, 0, 0, 1);
        wr(5'h08, 0, 16'h0040, cas_pkg::ACT_UDP_TX, 0, 0, 4'h9, 0, 1);
        wr(5'h08, 0, 16'h0040, cas_pkg::ACT_UDP_TX, 0, 0, 4'h8, 11'h5C1, 1);
        wr(5'h00, 0, 16'h0001, cas_pkg::ACT_CNT_SET, 1, 32'hFFFFFFFF, 0, 0, 0);
        wr(5'h01, 0, 16'h0001, cas_pkg::ACT_CNT_INC, 1, 0, 0, 0, 0);
        wr(5'h02, 0, 16'h0006, cas_pkg::ACT_CNT_INC, 2, 0, 0, 0, 0);
        wr(5'h03, 0, 16'h0008, cas_pkg::ACT_GPIO_SET, 4, 1, 0, 0, 0);
        wr(5'h04, 0, 16'h0010, cas_pkg::ACT_HIBERN, 0, 0, 0, 0, 0);
        wr(5'h05, 0, 16'h0020, cas_pkg::ACT_TMR_CTL, 0, 2, 0, 0, 0);
        wr(5'h06, 0, 16'h0100, cas_pkg::ACT_CNT_INC, 3, 0, 0, 0, 0);
        wr(5'h07, 1, 16'h0000, cas_pkg::ACT_HW_IND, 5, 0, 0, 0, 0);
        for (int k = 0; k < 3; k++) begin
            wr(5'(9 + k), 0, 16'h0080, snd[k], 0, 0, 4'h8, 11'h5C0, 0);
        end
        wr(5'h0F, 0, 16'h0040, cas_pkg::ACT_CNT_INC, 4, 0, 0, 0, 0);
        ev = 8'h01;
        repeat (6) @(negedge clk);
        rd(1, 0);
        ev = 8'h03;
        repeat (6) @(negedge clk);
        rd(2, 0);
        ev = 8'h07;
        repeat (6) @(negedge clk);
        rd(2, 1);
        ev = 8'h47;
        repeat (6) @(negedge clk);
        check(act_valid, 0);
        rd(4, 1);
        ev = 8'h4F;
        take(cas_pkg::ACT_GPIO_SET, 3, 4, 1, 0, 0);
        repeat (3) @(negedge clk);
        check(gpio_out[4], 1);
        ev = 8'h5F;
        take(cas_pkg::ACT_HIBERN, 4, 0, 0, 0, 0);
        repeat (2) @(negedge clk);
        check(hib, 1);
        wake = 1;
        @(negedge clk);
        wake = 0;
        @(negedge clk);
        check(hib, 0);
        ev = 8'hDF;
        for (int k = 0; k < 3; k++) begin
            take(snd[k], 4'(9 + k), 0, 0, 4'h8, 11'h5C0);
        end
        ev = 8'hFF;
        repeat (8) @(negedge clk);
        check(tmr_running[0], 1);
        rd(3, 0);
        repeat (50) @(negedge clk);
        rd(3, 1);
        check(tmr_running[0], 0);
        pre_init = 1;
        take(cas_pkg::ACT_HW_IND, 7, 5, 0, 0, 0);
        core_ind = 1;
        repeat (3) @(negedge clk);
        check(gpio_out[5], 1);
        core_ind = 0;
        repeat (3) @(negedge clk);
        check(gpio_out[5], 0);
        // mid-run reset must clear pins, requests and counters
        rst = 1;
        @(negedge clk);
        rst = 0;
        check({act_valid, hib, gpio_out}, 0);
        check(tmr_running, 0);
        rd(3, 0);
        results();
    end
endmodule

// ==== tb/cas_top_sva.sv ====
// concurrent checks on the scripter top level ports
// assumes one clock domain and a bind onto every cas_top instance
module cas_top_chk #(
    parameter int TICK_CYC = 20
) (
    input wire logic              clk,        // clock
    input wire logic              rst,        // reset
    input wire logic              pre_init,   // init phase
    input wire logic              wake,       // wake
    input wire logic              cfg_we,     // write strobe
    input wire logic [4:0]        cfg_idx,    // index
    input wire logic              cfg_init,   // init entry
    input wire cas_pkg::cas_act_t cfg_act,    // action
    input wire logic [3:0]        cfg_tokens, // tokens
    input wire logic [10:0]       cfg_len,    // length
    input wire logic              cfg_ack,    // accepted
    input wire logic              cfg_err,    // refused
    input wire logic              act_valid,  // core request
    input wire logic              act_ready,  // core takes
    input wire cas_pkg::cas_act_t act_kind,   // requested action
    input wire logic [31:0]       act_value,  // value
    input wire logic              hib         // hibernate
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_idx_refused: assert property (cfg_we && cfg_idx >= cas_pkg::IDX_LIMIT |=>
        cfg_err && !cfg_ack) else $error("index beyond table not refused");
    chk_tok_refused: assert property (cfg_we && cfg_tokens > cas_pkg::TOK_MAX |=>
        cfg_err) else $error("token count not refused");
    chk_len_refused: assert property (cfg_we && cfg_len > cas_pkg::LEN_MAX |=>
        cfg_err) else $error("payload length not refused");
    chk_init_refused: assert property (cfg_we && !cfg_init &&
        cfg_act >= cas_pkg::ACT_SET_ROLE |=> cfg_err) else $error("init action accepted");
    chk_good_write: assert property (cfg_we && cfg_idx < cas_pkg::IDX_LIMIT &&
        cfg_tokens <= cas_pkg::TOK_MAX && cfg_len <= cas_pkg::LEN_MAX &&
        (cfg_init || cfg_act < cas_pkg::ACT_SET_ROLE) |=> cfg_ack) else $error("write refused");
    chk_ans_cause: assert property ((cfg_ack || cfg_err) |-> $past(cfg_we) &&
        !(cfg_ack && cfg_err)) else $error("stray write answer");
    chk_req_hold: assert property (act_valid && !act_ready |=> act_valid &&
        $stable(act_kind) && $stable(act_value)) else $error("request dropped or changed");
    chk_core_kind: assert property (act_valid |-> !(act_kind inside {cas_pkg::ACT_NONE,
        cas_pkg::ACT_CNT_INC, cas_pkg::ACT_CNT_SET, cas_pkg::ACT_TMR_CTL}))
        else $error("internal action sent to core");
    chk_init_phase: assert property (act_valid && act_kind >= cas_pkg::ACT_SET_ROLE |->
        pre_init) else $error("init action outside init phase");
    chk_hib_enter: assert property (act_valid && act_ready && !wake &&
        act_kind == cas_pkg::ACT_HIBERN |-> ##[1:2] hib) else $error("hibernate not entered");
    chk_wake_wins: assert property (wake |=> !hib) else $error("wake ignored");

    cover property (cfg_err);
    cover property (act_valid && act_ready);
    cover property ($rose(hib));
endmodule

bind cas_top cas_top_chk #(.TICK_CYC(TICK_CYC)) i_chk (.clk(clk), .rst(rst),
    .pre_init(pre_init), .wake(wake), .cfg_we(cfg_we), .cfg_idx(cfg_idx),
    .cfg_init(cfg_init), .cfg_act(cfg_act), .cfg_tokens(cfg_tokens), .cfg_len(cfg_len),
    .cfg_ack(cfg_ack), .cfg_err(cfg_err), .act_valid(act_valid), .act_ready(act_ready),
    .act_kind(act_kind), .act_value(act_value), .hib(hib));
